// ==== poc_channel.sv ====
/*
  One pulse output channel: modulation and pulse train modes, software and
  hardware start, abort, count fault and status byte.
  Assumes synchronous inputs and a one-cycle read latency register port.
*/
// Our own choice: strobed register access.
// Contract
// [RULE1] Short or zero-factor period becomes twice minimum
// [RULE2] Forced period: output follows half-scale compare
// [RULE3] Period above 65.535 s is clamped (code: on the 0.1 ms base the clamp is 65535 ticks, 6.5535 s)
// [RULE4] Status bit 0 shows sequence running
// [RULE5] Status bit 1 mirrors output line
// [RULE6] Status bit 2 mirrors auxiliary input
// [RULE7] Status bit 3 echoes software enable
// [RULE8] Hardware go sampled; rising edge starts
// [RULE9] After delay emit configured pulse count
// [RULE10] Software raises go with manual bit low
// [RULE11] Go set: first hardware edge starts
// [RULE12] Hardware edges ignored while running
// [RULE13] Later hardware edge starts next sequence
// [RULE14] Start edge begins delay, sets active
// [RULE15] Sequence ends after last pulse
// [RULE16] Count fault set; cleared next start
// [RULE17] Dropping go aborts, clears active, output
// [RULE18] Lowered count already reached: stop, fault
// [RULE19] Factor change applies at next sequence (code: a running modulation sequence takes the new factor at its next period)
// [RULE20] Period is factor x 0.1 x period
// [RULE21] Output value clamped to full scale
// [RULE22] Start level follows delay; needs hardware high (code: a go edge starts only with a hardware rising edge in the same cycle)
// [RULE23] Tick of 0.1 ms or 1 ms
`timescale 1ns/1ps
module poc_channel import poc_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_aux_in,
  output logic o_pulse_out
);
  // ==========================================================
  // Registers
  logic go_r, go_nxt;
  logic manual_r, manual_nxt;
  logic [7:0] factor_r, factor_nxt;
  logic [15:0] value_r, value_nxt;
  logic [15:0] count_r, count_nxt;
  logic [15:0] period_r, period_nxt;
  logic [15:0] minp_r, minp_nxt;
  logic [15:0] delay_r, delay_nxt;
  logic [3:0] cfg_r, cfg_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic aux_prev_r, aux_prev_nxt;
  logic fault_r, fault_nxt;
  logic out_r, out_nxt;
  logic [7:0] seq_factor_r, seq_factor_nxt;
  logic [15:0] timer_r, timer_nxt;
  logic [15:0] done_r, done_nxt;
  logic [15:0] hi_r, hi_nxt;
  poc_state_t state_r, state_nxt;
  logic tick;
  logic [15:0] eff_period;
  logic [15:0] eff_high;
  logic forced;
  logic forced_level;
  logic [15:0] pt_period;
  logic [15:0] pt_high;
  logic [15:0] pt_minp;
  logic go_rise;
  logic hw_rise;
  logic start;
  logic active;

  poc_tick u_tick (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_slow(cfg_r[CF_SLOW]),
    .o_tick(tick)
  );

  // [RULE19] factor being written when idle, latched one during a train
  poc_pwm u_pwm (
    .i_period(period_r),
    .i_factor((state_r == POC_IDLE) ? factor_nxt : (cfg_r[CF_PWM] ? factor_r : seq_factor_r)),
    .i_min_pulse(minp_r),
    .i_value(value_r),
    .i_analog(cfg_r[CF_ANALOG]),
    .i_slow(cfg_r[CF_SLOW]),
    .o_period(eff_period),
    .o_high(eff_high),
    .o_forced(forced),
    .o_forced_level(forced_level)
  );

  // ==========================================================
  // Register port
  always_comb begin
    go_nxt = go_r;
    manual_nxt = manual_r;
    factor_nxt = factor_r;
    value_nxt = value_r;
    count_nxt = count_r;
    period_nxt = period_r;
    minp_nxt = minp_r;
    delay_nxt = delay_r;
    cfg_nxt = cfg_r;
    rdata_nxt = '0;
    if (i_wr) begin
      if (i_addr == ADDR_CTRL) begin
        go_nxt = i_wdata[CT_GO];
        manual_nxt = i_wdata[CT_MANUAL];
        factor_nxt = i_wdata[CT_FACTOR_LO +: 8];
      end else if (i_addr == ADDR_VALUE) begin
        value_nxt = i_wdata[15:0];
      end else if (i_addr == ADDR_COUNT) begin
        count_nxt = i_wdata[15:0];
      end else if (i_addr == ADDR_PERIOD) begin
        period_nxt = i_wdata[15:0];
      end else if (i_addr == ADDR_MINPULSE) begin
        minp_nxt = i_wdata[15:0];
      end else if (i_addr == ADDR_DELAY) begin
        delay_nxt = i_wdata[15:0];
      end else if (i_addr == ADDR_CONFIG) begin
        cfg_nxt = i_wdata[3:0];
      end
    end
    if (i_rd) begin
      if (i_addr == ADDR_STATUS) begin
        // [RULE4] active bit
        rdata_nxt[ST_ACTIVE] = active;
        // [RULE5] output level
        rdata_nxt[ST_OUT] = out_r;
        // [RULE6] input level
        rdata_nxt[ST_IN] = i_aux_in;
        // [RULE7] go echo
        rdata_nxt[ST_ECHO] = go_r;
        rdata_nxt[ST_FAULT] = fault_r;
      end else if (i_addr == ADDR_CTRL) begin
        rdata_nxt = {16'h0000, factor_r, 6'h00, manual_r, go_r};
      end else if (i_addr == ADDR_VALUE) begin
        rdata_nxt = {16'h0000, value_r};
      end else if (i_addr == ADDR_COUNT) begin
        rdata_nxt = {16'h0000, count_r};
      end else if (i_addr == ADDR_PERIOD) begin
        rdata_nxt = {16'h0000, period_r};
      end else if (i_addr == ADDR_MINPULSE) begin
        rdata_nxt = {16'h0000, minp_r};
      end else if (i_addr == ADDR_DELAY) begin
        rdata_nxt = {16'h0000, delay_r};
      end else if (i_addr == ADDR_CONFIG) begin
        rdata_nxt = {28'h000_0000, cfg_r};
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      go_r <= 1'b0;
      manual_r <= 1'b0;
      factor_r <= 8'h00;
      value_r <= 16'h0000;
      count_r <= 16'h0000;
      period_r <= RST_PERIOD;
      minp_r <= RST_MINPULSE;
      delay_r <= 16'h0000;
      cfg_r <= 4'h0;
      rdata_r <= 32'h0000_0000;
    end else begin
      go_r <= go_nxt;
      manual_r <= manual_nxt;
      factor_r <= factor_nxt;
      value_r <= value_nxt;
      count_r <= count_nxt;
      period_r <= period_nxt;
      minp_r <= minp_nxt;
      delay_r <= delay_nxt;
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_pulse_out = out_r;
  assign active = (state_r != POC_IDLE);

  // ==========================================================
  // Sequencer
  always_comb begin
    // [RULE10] start only with manual bit low
    go_rise = go_nxt && !go_r && !manual_nxt;
    // [RULE8] hardware go edge
    hw_rise = i_aux_in && !aux_prev_r;
    // [RULE11] [RULE22] hardware edge needs go set; go edge needs a hardware rising edge in the same cycle
    if (cfg_r[CF_HWGO]) begin
      start = (go_r && go_nxt && hw_rise) || (go_rise && i_aux_in && !aux_prev_r);
    end else begin
      start = go_rise;
    end
    pt_minp = (minp_r < (cfg_r[CF_SLOW] ? MIN_PULSE_SLOW : MIN_PULSE_FAST)) ?
              (cfg_r[CF_SLOW] ? MIN_PULSE_SLOW : MIN_PULSE_FAST) : minp_r;
    pt_high = pt_minp;
    // [RULE20] train period also scaled by factor; never below twice the pulse
    pt_period = eff_period;
    state_nxt = state_r;
    timer_nxt = timer_r;
    done_nxt = done_r;
    out_nxt = out_r;
    hi_nxt = hi_r;
    fault_nxt = fault_r;
    seq_factor_nxt = seq_factor_r;
    aux_prev_nxt = i_aux_in;
    case (state_r)
      POC_IDLE: begin
        out_nxt = 1'b0;
        // [RULE12] [RULE13] edges only count when idle
        if (start) begin
          // [RULE14] [RULE16] begin delay, clear fault
          fault_nxt = 1'b0;
          seq_factor_nxt = factor_nxt;
          done_nxt = 16'h0000;
          timer_nxt = delay_r;
          if (delay_r == 16'h0000) begin
            // [RULE22] zero delay drives high at once
            state_nxt = POC_HIGH;
            out_nxt = 1'b1;
            timer_nxt = cfg_r[CF_PWM] ? eff_high : pt_high;
            hi_nxt = cfg_r[CF_PWM] ? eff_period - eff_high : pt_period - pt_high;
          end else begin
            state_nxt = POC_DELAY;
          end
        end
      end
      POC_DELAY: begin
        if (tick) begin
          timer_nxt = timer_r - 1'b1;
          if (timer_r == 16'h0001) begin
            state_nxt = POC_HIGH;
            out_nxt = 1'b1;
            timer_nxt = cfg_r[CF_PWM] ? eff_high : pt_high;
            hi_nxt = cfg_r[CF_PWM] ? eff_period - eff_high : pt_period - pt_high;
          end
        end
      end
      POC_HIGH: begin
        if (cfg_r[CF_PWM] && forced) begin
          // [RULE2] forced level held
          out_nxt = forced_level;
        end else if (tick) begin
          timer_nxt = timer_r - 1'b1;
          if (timer_r <= 16'h0001) begin
            done_nxt = done_r + 1'b1;
            out_nxt = 1'b0;
            timer_nxt = hi_r;
            state_nxt = POC_LOW;
            // [RULE9] [RULE15] last pulse ends sequence
            if (!cfg_r[CF_PWM] && (done_r + 1'b1) >= count_r) begin
              state_nxt = POC_IDLE;
            end
          end
        end
      end
      POC_LOW: begin
        if (tick) begin
          timer_nxt = timer_r - 1'b1;
          if (timer_r <= 16'h0001) begin
            state_nxt = POC_HIGH;
            out_nxt = 1'b1;
            timer_nxt = cfg_r[CF_PWM] ? eff_high : pt_high;
            hi_nxt = cfg_r[CF_PWM] ? eff_period - eff_high : pt_period - pt_high;
          end
        end
        // [RULE18] lowered count already emitted
        if (!cfg_r[CF_PWM] && done_r >= count_r) begin
          state_nxt = POC_IDLE;
          out_nxt = 1'b0;
          fault_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = POC_IDLE;
      end
    endcase
    // [RULE17] dropping go aborts
    if (!go_nxt && state_r != POC_IDLE) begin
      state_nxt = POC_IDLE;
      out_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= POC_IDLE;
      timer_r <= 16'h0000;
      done_r <= 16'h0000;
      out_r <= 1'b0;
      hi_r <= 16'h0000;
      fault_r <= 1'b0;
      seq_factor_r <= 8'h00;
      aux_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      done_r <= done_nxt;
      out_r <= out_nxt;
      hi_r <= hi_nxt;
      fault_r <= fault_nxt;
      seq_factor_r <= seq_factor_nxt;
      aux_prev_r <= aux_prev_nxt;
    end
  end
endmodule // poc_channel

// ==== poc_pkg.sv ====
/*
  Shared constants for one pulse output channel: register map, status bit
  positions, limits and time-base figures.
  Assumes a 25 MHz system clock and plain strobe register access.
*/
package poc_pkg;
  // ==========================================================
  // Clock and time base
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_FAST_NS = 100_000;
  localparam int unsigned TICK_SLOW_NS = 1_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_FAST_CYC = TICK_FAST_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_SLOW_CYC = TICK_SLOW_NS / CLK_PERIOD_NS;
  localparam int unsigned TB_W = 15;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_VALUE = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_PERIOD = 8'h14;
  localparam logic [7:0] ADDR_MINPULSE = 8'h18;
  localparam logic [7:0] ADDR_DELAY = 8'h1C;
  localparam logic [7:0] ADDR_CONFIG = 8'h20;
  // Status bits
  localparam int unsigned ST_ACTIVE = 0;
  localparam int unsigned ST_OUT = 1;
  localparam int unsigned ST_IN = 2;
  localparam int unsigned ST_ECHO = 3;
  localparam int unsigned ST_FAULT = 4;
  // Control bits
  localparam int unsigned CT_GO = 0;
  localparam int unsigned CT_MANUAL = 1;
  localparam int unsigned CT_FACTOR_LO = 8;
  // Config bits
  localparam int unsigned CF_PWM = 0;
  localparam int unsigned CF_SLOW = 1;
  localparam int unsigned CF_HWGO = 2;
  localparam int unsigned CF_ANALOG = 3;
  // Reset values
  localparam logic [15:0] RST_MINPULSE = 16'h2710;
  localparam logic [15:0] RST_PERIOD = 16'h4E20;
  // ==========================================================
  // Modulation limits
  localparam logic [15:0] VAL_MAX_MILL = 16'h03E8;
  localparam logic [15:0] VAL_MAX_ANA = 16'h6C00;
  localparam logic [15:0] VAL_HALF_MILL = 16'h01F4;
  localparam logic [15:0] VAL_HALF_ANA = 16'h3600;
  localparam logic [15:0] MIN_PULSE_FAST = 16'h0002;
  localparam logic [15:0] MIN_PULSE_SLOW = 16'h0001;
  localparam logic [15:0] FLOOR_US_FAST = 16'h0004;
  localparam logic [15:0] FLOOR_US_SLOW = 16'h0001;
  localparam logic [15:0] PERIOD_MAX_SLOW = 16'hFFFF;
  localparam logic [7:0] FACTOR_DIV = 8'h0A;
  typedef enum logic [3:0] {
    POC_IDLE = 4'b0001,
    POC_DELAY = 4'b0010,
    POC_HIGH = 4'b0100,
    POC_LOW = 4'b1000
  } poc_state_t;
endpackage

// ==== poc_tick.sv ====
/*
  Time-base tick generator: one-cycle pulse every 0.1 ms or 1 ms.
  Assumes the 25 MHz system clock from the package.
*/
`timescale 1ns/1ps
module poc_tick import poc_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_slow,
  output logic o_tick
);
  logic [TB_W-1:0] cnt_r;
  logic [TB_W-1:0] cnt_nxt;
  logic [TB_W-1:0] last;

  always_comb begin
    last = i_slow ? TB_W'(TICK_SLOW_CYC - 1) : TB_W'(TICK_FAST_CYC - 1);
    cnt_nxt = (cnt_r >= last) ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // [RULE23] tick from clock
  assign o_tick = (cnt_r >= last);
endmodule // poc_tick

// ==== poc_pwm.sv ====
/*
  Effective modulation period and pulse width for one channel.
  Pure arithmetic; the caller latches the results at period start.
  Times are in ticks of the selected time base.
*/
`timescale 1ns/1ps
module poc_pwm import poc_pkg::*; (
  input wire logic [15:0] i_period,
  input wire logic [7:0] i_factor,
  input wire logic [15:0] i_min_pulse,
  input wire logic [15:0] i_value,
  input wire logic i_analog,
  input wire logic i_slow,
  output logic [15:0] o_period,
  output logic [15:0] o_high,
  output logic o_forced,
  output logic o_forced_level
);
  logic [23:0] prod;
  logic [23:0] raw;
  logic [16:0] twice_min;
  logic [15:0] minp;
  logic [15:0] val;
  logic [15:0] vmax;
  logic [31:0] hi;

  always_comb begin
    minp = (i_min_pulse < (i_slow ? MIN_PULSE_SLOW : MIN_PULSE_FAST)) ?
           (i_slow ? MIN_PULSE_SLOW : MIN_PULSE_FAST) : i_min_pulse;
    twice_min = {minp, 1'b0};
    // [RULE20] factor x 0.1 x period
    prod = i_period * i_factor;
    raw = prod / 24'(FACTOR_DIV);
    // [RULE21] output value clamp
    vmax = i_analog ? VAL_MAX_ANA : VAL_MAX_MILL;
    val = (i_value > vmax) ? vmax : i_value;
    // [RULE1] degenerate period floor
    o_forced = (i_factor == 8'h00) || (raw < 24'(twice_min)) ||
               (raw < 24'(i_slow ? FLOOR_US_SLOW : FLOOR_US_FAST));
    // [RULE3] clamp to 65535 ticks (65.535 s on the slow base)
    if (o_forced) begin
      o_period = twice_min[16] ? PERIOD_MAX_SLOW : twice_min[15:0];
    end else if (i_slow && raw > 24'(PERIOD_MAX_SLOW)) begin
      o_period = PERIOD_MAX_SLOW;
    end else if (raw > 24'(PERIOD_MAX_SLOW)) begin
      // Fast base cannot express 65.535 s; saturate the counter width
      o_period = PERIOD_MAX_SLOW;
    end else begin
      o_period = raw[15:0];
    end
    // [RULE2] level vs half scale
    o_forced_level = val > (i_analog ? VAL_HALF_ANA : VAL_HALF_MILL);
    hi = (32'(o_period) * 32'(val)) / 32'(vmax);
    o_high = hi[15:0];
  end
endmodule // poc_pwm

// ==== poc_channel_assertions.sv ====
/* Port-level checker for one pulse output channel.
   Sees only the top ports; bound to poc_channel below. */
`timescale 1ns/1ps
module poc_chk import poc_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_aux_in,
  input wire logic o_pulse_out
);
  // ==========================================
  // Shadow of control, config, delay and count writes
  logic go_r, go_nxt, dz_r, dz_nxt, cn_r, cn_nxt;
  logic [3:0] cf_r, cf_nxt;
  always_comb begin
    go_nxt = go_r;
    cf_nxt = cf_r;
    dz_nxt = dz_r;
    cn_nxt = cn_r;
    if (i_wr && i_addr == ADDR_CTRL) go_nxt = i_wdata[CT_GO];
    if (i_wr && i_addr == ADDR_CONFIG) cf_nxt = i_wdata[3:0];
    if (i_wr && i_addr == ADDR_DELAY) dz_nxt = (i_wdata[15:0] == 16'h0000);
    if (i_wr && i_addr == ADDR_COUNT) cn_nxt = (i_wdata[15:0] != 16'h0000);
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      go_r <= 1'b0;
      cf_r <= 4'h0;
      dz_r <= 1'b1;
      cn_r <= 1'b0;
    end else begin
      go_r <= go_nxt;
      cf_r <= cf_nxt;
      dz_r <= dz_nxt;
      cn_r <= cn_nxt;
    end
  end
  // ==========================================
  // Properties
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence go_rise_s;
    i_wr && i_addr == ADDR_CTRL && i_wdata[CT_GO] && !i_wdata[CT_MANUAL] && !go_r;
  endsequence
  sequence stat_rd_s;
    i_rd && i_addr == ADDR_STATUS;
  endsequence
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  stat_upper_a: assert property (stat_rd_s |=> o_rdata[31:5] == 27'h0)
    else $error("status upper bits not zero");
  unmapped_rd_a: assert property (i_rd && i_addr == 8'h04 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  out_mirror_a: assert property (stat_rd_s |=>
    o_rdata[ST_OUT] == $past(o_pulse_out) || o_rdata[ST_OUT] == o_pulse_out)
    else $error("output flag differs from line");
  aux_mirror_a: assert property (stat_rd_s |=>
    o_rdata[ST_IN] == $past(i_aux_in) || o_rdata[ST_IN] == $past(i_aux_in, 2))
    else $error("input flag differs from line");
  go_echo_a: assert property (stat_rd_s |=> o_rdata[ST_ECHO] == $past(go_r))
    else $error("echo bit differs from go");
  abort_clr_a: assert property (i_wr && i_addr == ADDR_CTRL && !i_wdata[CT_GO]
    |-> ##2 !o_pulse_out) else $error("output not cleared on abort");
  start_high_a: assert property (go_rise_s and cf_r == 4'h0 && dz_r && cn_r
    |=> o_pulse_out) else $error("zero delay start not high");
  hw_hold_a: assert property (go_rise_s and cf_r[CF_HWGO] && !cf_r[CF_PWM]
    && !i_aux_in |=> !o_pulse_out) else $error("started without hardware go");
endmodule // poc_chk

bind poc_channel poc_chk poc_chk_inst (
  .i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_aux_in(i_aux_in),
  .o_pulse_out(o_pulse_out)
);

// ==== poc_actuator.sv ====
/* Actuator model: drives the hardware go line and counts pulses.
   Assumes the bench commands the go level; it may answer a cycle late. */
`timescale 1ns/1ps
module poc_actuator (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_pulse,
  input wire logic i_want,
  input wire logic i_late,
  output logic o_aux,
  output int o_pulses
);
  logic prev_r, want_r;
  // ==========================================
  // Go line is always driven; a late answer lags one cycle
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_aux <= 1'b0;
      want_r <= 1'b0;
      prev_r <= 1'b0;
      o_pulses <= 0;
    end else begin
      want_r <= i_want;
      o_aux <= i_late ? want_r : i_want;
      prev_r <= i_pulse;
      if (i_pulse && !prev_r) o_pulses <= o_pulses + 1;
    end
  end
endmodule // poc_actuator

// ==== pulse_output_channel_tb_top.sv ====
/* Self-checking bench for one pulse output channel.
   Assumes the actuator model and the bound checker are compiled first. */
`timescale 1ns/1ps
module pulse_output_channel_tb_top import poc_pkg::*;;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic i_aux_in;
  logic o_pulse_out;
  logic want = 1'b0;
  logic late = 1'b0;
  logic [31:0] d;
  logic [15:0] v;
  int pulses, base, i, k;
  int fails = 0;
  int checks = 0;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end

  always #20 i_sys_clk = ~i_sys_clk;

  poc_channel poc_channel_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_aux_in(i_aux_in), .o_pulse_out(o_pulse_out));
  poc_actuator poc_actuator_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_pulse(o_pulse_out), .i_want(want), .i_late(late), .o_aux(i_aux_in),
    .o_pulses(pulses));

  // ==========================================
  // Reference status byte and bus tasks
  function automatic logic [31:0] exp_st(int act, int out, int aux, int go, int flt);
    return 32'(flt * 16 + go * 8 + aux * 4 + out * 2 + act);
  endfunction
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= x;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    x = o_rdata;
  endtask
  task automatic wait_pulses(input int n);
    int k;
    for (k = 0; k < 40000 && pulses - base < n; k++) @(posedge i_sys_clk);
    if (pulses - base < n) begin
      fails++;
      give_verdict();
    end
  endtask
  // Polls status until the sequence ends; d keeps the last read
  task automatic wait_idle;
    int k;
    d = 32'h0000_0001;
    for (k = 0; k < 20000 && d[ST_ACTIVE] !== 1'b0; k++) rd(ADDR_STATUS, d);
    if (d[ST_ACTIVE] !== 1'b0) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic go(input logic [31:0] x);
    // every caller keeps the manual bit low
    wr(ADDR_CTRL, x);
  endtask

  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(32'h1520_2f1a));
    repeat (16) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rd(ADDR_PERIOD, d); `CHK(d, 32'h0000_4E20)
    rd(ADDR_MINPULSE, d); `CHK(d, 32'h0000_2710)
    rd(8'h04, d); `CHK(d, 32'h0000_0000)
    rd(ADDR_STATUS, d); `CHK(d, exp_st(0, 0, 0, 0, 0))
    wr(ADDR_MINPULSE, 32'h0000_0002);
    wr(ADDR_PERIOD, 32'h0000_0003);
    wr(ADDR_COUNT, 32'h0000_0002);
    // Software start, zero delay, two pulses
    base = pulses;
    go(32'h0000_0001);
    rd(ADDR_STATUS, d); `CHK(d, exp_st(1, 1, 0, 1, 0))
    wait_idle();
    `CHK(pulses - base, 2)
    `CHK(d, exp_st(0, 0, 0, 1, 0))
    // Abort during the on-delay
    go(32'h0000_0000);
    wr(ADDR_DELAY, 32'h0000_0003);
    base = pulses;
    go(32'h0000_0001);
    rd(ADDR_STATUS, d); `CHK(d, exp_st(1, 0, 0, 1, 0))
    go(32'h0000_0000);
    rd(ADDR_STATUS, d); `CHK(d, exp_st(0, 0, 0, 0, 0))
    repeat (8000) @(posedge i_sys_clk);
    `CHK(pulses - base, 0)
    // Hardware go, with an ignored extra edge and a restart
    wr(ADDR_DELAY, 32'h0000_0000);
    wr(ADDR_COUNT, 32'h0000_0001);
    wr(ADDR_CONFIG, 32'h0000_0004);
    base = pulses;
    go(32'h0000_0001);
    rd(ADDR_STATUS, d); `CHK(d, exp_st(0, 0, 0, 1, 0))
    @(posedge i_sys_clk);
    want <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    rd(ADDR_STATUS, d); `CHK(d, exp_st(1, 1, 1, 1, 0))
    want <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    want <= 1'b1;
    wait_idle();
    `CHK(pulses - base, 1)
    `CHK(d, exp_st(0, 0, 1, 1, 0))
    late <= 1'b1;
    want <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    want <= 1'b1;
    wait_pulses(2);
    wait_idle();
    // Count lowered below pulses already sent
    wr(ADDR_CONFIG, 32'h0000_0000);
    wr(ADDR_COUNT, 32'h0000_0003);
    go(32'h0000_0000);
    base = pulses;
    go(32'h0000_0001);
    wait_pulses(2);
    repeat (5200) @(posedge i_sys_clk);
    wr(ADDR_COUNT, 32'h0000_0001);
    rd(ADDR_STATUS, d); `CHK(d, exp_st(0, 0, 1, 1, 1))
    go(32'h0000_0000);
    go(32'h0000_0001);
    rd(ADDR_STATUS, d); `CHK(d, exp_st(1, 1, 1, 1, 0))
    wait_idle();
    // Modulation with factor zero: forced period, level from value
    wr(ADDR_CONFIG, 32'h0000_0001);
    for (i = 0; i < 3; i++) begin
      v = (i == 0) ? 16'($urandom_range(1000, 501)) :
          (i == 1) ? 16'($urandom_range(499, 0)) : 16'($urandom_range(65535, 1001));
      go(32'h0000_0000);
      wr(ADDR_VALUE, {16'h0000, v});
      go(32'h0000_0001);
      repeat (20) @(posedge i_sys_clk);
      rd(ADDR_STATUS, d); `CHK(d, exp_st(1, i != 1, 1, 1, 0))
    end
    go(32'h0000_0000);
    // Train period is factor 25 x 0.1 x 2 ticks; a factor change mid-run must not count
    wr(ADDR_CONFIG, 32'h0000_0000);
    wr(ADDR_PERIOD, 32'h0000_0002);
    wr(ADDR_COUNT, 32'h0000_0003);
    base = pulses;
    go(32'h0000_1901);
    go(32'h0000_0001);
    wait_pulses(2);
    for (k = 0; k < 20000 && pulses - base < 3; k++) @(posedge i_sys_clk);
    `CHK((k + 50) / 100, 5 * TICK_FAST_CYC / 100)
    wait_idle();
    `CHK(pulses - base, 3)
    give_verdict();
  end
endmodule // pulse_output_channel_tb_top
